// file: src/bctr_params.svh
// register offsets, control bits, reset values and counts of the bus-cycle trace recorder
`ifndef BCTR_PARAMS_SVH
`define BCTR_PARAMS_SVH
`define BCTR_OFF_CTRL 8'h00
`define BCTR_OFF_DLY 8'h04
`define BCTR_OFF_STAT 8'h08
`define BCTR_OFF_SEL 8'h0C
`define BCTR_OFF_EADDR 8'h10
`define BCTR_OFF_EDATA 8'h14
`define BCTR_OFF_EINFO 8'h18
`define BCTR_OFF_ETIME 8'h1C
`define BCTR_OFF_EIDX 8'h20
`define BCTR_CTRL_EN 0
`define BCTR_CTRL_TS 1
`define BCTR_CTRL_IDXBUS 2
`define BCTR_CTRL_CLR 3
`define BCTR_CTRL_RST 3'h0
`define BCTR_DLY_RST 16'h0000
`define BCTR_SEL_RST 16'h0000
`define BCTR_CLK_MAX 8'hFF
`define BCTR_DEPTH 256
`endif

// file: src/bctr_pkg.sv
// types shared by the bus-cycle trace recorder
package bctr_pkg;
  typedef enum logic [1:0] {BCTR_AREA_IO, BCTR_AREA_INT, BCTR_AREA_EXT} bctr_area_t;
  typedef enum logic [2:0] {BCTR_STS_FETCH, BCTR_STS_DATA, BCTR_STS_DMA, BCTR_STS_VECT, BCTR_STS_REFR} bctr_sts_t;
  typedef enum logic [1:0] {BCTR_SZ_BYTE, BCTR_SZ_WORD, BCTR_SZ_LONG} bctr_size_t;
  typedef enum logic [1:0] {BCTR_IDLE, BCTR_RUN, BCTR_DELAY, BCTR_DONE} bctr_state_t;
  // target bus and pin levels, valid with the cycle-end strobe
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    bctr_size_t size;
    logic rw;
    logic io_hit;
    logic int_hit;
    bctr_sts_t sts;
    logic [3:0] interrupt_request_level;
    logic nmi;
    logic res;
    logic bus_request_level;
    logic vcc_ok;
    logic [3:0] probe;
    logic [1:0] insn_cnt;
  } bctr_bus_t;
  // info word as software reads it
  typedef struct packed {
    logic [5:0] zero;
    logic [1:0] insn_cnt;
    logic ovf;
    logic marker;
    logic [3:0] probe;
    logic vcc_ok;
    logic bus_request_level;
    logic res;
    logic nmi;
    logic [3:0] interrupt_request_level;
    bctr_sts_t sts;
    logic rw;
    bctr_area_t area;
    logic [3:0] lanes;
  } bctr_info_t;
  // one stored trace entry
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    bctr_info_t info;
    logic [15:0] insn_no;
    logic [31:0] time_val;
  } bctr_rec_t;
endpackage : bctr_pkg

// file: src/bctr_top.sv
// bus-cycle trace recorder: captures one entry per target bus cycle, read back over apb
//
// What this block does
// R1: one entry per bus cycle, all fields
// R2: area is internal io, internal, else external
// R3: status holds five cycle kinds
// R4: interrupt level pins as 4-bit field
// R5: nmi, reset, bus request as bits
// R6: supply-ok bit per entry
// R7: four probe inputs per entry
// R8: unused byte lanes flagged not accessed
// R9: saturating clock count with overflow flag
// R10: clock count or time stamp, not both
// R11: time stamp off after reset
// R12: indices relative to delay start entry
// R13: entries during delay get positive indices
// R14: no delay start: relative to latest entry
// R15: two-instruction fetch keeps first address
// R16: bus or instruction index, instruction default
// R17: circular buffer overwrites oldest entry
// R18: marker entry after last user cycle
//
// Local design decisions: the address map and the APB register port.
`include "bctr_params.svh"
module bctr_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // target bus sampling
  input wire bctr_pkg::bctr_bus_t tgt,
  input wire logic cyc_end,
  input wire logic delay_start,
  input wire logic run_end,
  // status
  output logic trace_busy
);
  import bctr_pkg::*;

  bctr_rec_t mem [`BCTR_DEPTH];
  bctr_state_t state;
  logic [2:0] ctrl;
  logic [15:0] dly_len;
  logic [15:0] dly_cnt;
  logic [15:0] sel;
  logic [7:0] wptr;
  logic [7:0] ref_reg;
  logic [15:0] ref_insn_reg;
  logic [15:0] insn_no;
  logic [15:0] last_insn;
  logic wrapped;
  logic dly_seen;
  logic mark_pend;
  logic [7:0] clk_run;
  logic [31:0] tstamp;
  logic capturing;
  logic we_cyc;
  logic we_mark;
  logic start_now;
  logic dly_expire;
  bctr_rec_t next_rec;
  bctr_rec_t rd_rec;
  logic [7:0] ref_pos;
  logic [15:0] ref_insn;
  logic [15:0] idx_val;
  logic apb_acc;
  logic apb_wr;
  logic clr;
  logic [3:0] cur_lanes;

  // byte lanes used by the access, big-endian lane 3 at offset 0
  function automatic logic [3:0] lane_mask(input bctr_size_t sz, input logic [1:0] a);
    case (sz)
      BCTR_SZ_LONG: lane_mask = 4'hF;
      BCTR_SZ_WORD: lane_mask = a[1] ? 4'h3 : 4'hC;
      default: lane_mask = 4'h8 >> a;
    endcase
  endfunction

  // known offsets answer, the rest raise pslverr
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      `BCTR_OFF_CTRL, `BCTR_OFF_DLY, `BCTR_OFF_STAT, `BCTR_OFF_SEL, `BCTR_OFF_EADDR,
      `BCTR_OFF_EDATA, `BCTR_OFF_EINFO, `BCTR_OFF_ETIME, `BCTR_OFF_EIDX: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  assign apb_acc = psel & penable & ~pready;
  assign apb_wr = apb_acc & pwrite & reg_hit(paddr);
  assign clr = apb_wr & (paddr == `BCTR_OFF_CTRL) & pwdata[`BCTR_CTRL_CLR];
  assign capturing = (state == BCTR_RUN) | (state == BCTR_DELAY);
  assign we_cyc = capturing & cyc_end; // R1
  // a pending marker yields to a real cycle so no user cycle is lost
  assign we_mark = capturing & mark_pend & ~cyc_end; // R18
  assign start_now = we_cyc & (state == BCTR_RUN) & delay_start; // R13
  assign dly_expire = we_cyc & (state == BCTR_DELAY) & (dly_cnt == dly_len);
  // lane mask decoded once, shared by data masking and the info word
  assign cur_lanes = lane_mask(tgt.size, tgt.addr[1:0]); // R8

  // build the entry from the sampled pins
  always_comb
  begin
    next_rec = '0;
    next_rec.addr = tgt.addr; // R15
    next_rec.data = tgt.data & {{8{cur_lanes[3]}}, {8{cur_lanes[2]}}, {8{cur_lanes[1]}}, {8{cur_lanes[0]}}};
    next_rec.info.lanes = cur_lanes; // R8
    next_rec.info.area = tgt.io_hit ? BCTR_AREA_IO : (tgt.int_hit ? BCTR_AREA_INT : BCTR_AREA_EXT); // R2
    next_rec.info.rw = tgt.rw;
    next_rec.info.sts = tgt.sts; // R3
    next_rec.info.interrupt_request_level = tgt.interrupt_request_level; // R4
    next_rec.info.nmi = tgt.nmi; // R5
    next_rec.info.res = tgt.res; // R5
    next_rec.info.bus_request_level = tgt.bus_request_level; // R5
    next_rec.info.vcc_ok = tgt.vcc_ok; // R6
    next_rec.info.probe = tgt.probe; // R7
    next_rec.info.insn_cnt = tgt.insn_cnt; // R15
    next_rec.info.ovf = (clk_run == `BCTR_CLK_MAX); // R9
    next_rec.insn_no = insn_no;
    // the time field carries one of the two, chosen by the control bit
    if (ctrl[`BCTR_CTRL_TS])
      next_rec.time_val = tstamp; // R10
    else
      next_rec.time_val = {24'h000000, (clk_run == `BCTR_CLK_MAX) ? `BCTR_CLK_MAX : clk_run + 8'h01}; // R9 R10
    if (we_mark)
    begin
      next_rec = '0;
      next_rec.info.marker = 1'b1; // R18
      next_rec.insn_no = insn_no;
    end
  end

  // trace store, never reset; the write pointer wraps over the oldest entry
  always_ff @(posedge pclk)
  begin
    if (we_cyc | we_mark)
      mem[wptr] <= next_rec;
  end

  // write pointer and wrap flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr <= 8'h00;
      wrapped <= 1'b0;
    end
    else if (clr)
    begin
      wptr <= 8'h00;
      wrapped <= 1'b0;
    end
    else if (we_cyc | we_mark)
    begin
      wptr <= wptr + 8'h01; // R17
      if (wptr == 8'hFF)
        wrapped <= 1'b1;
    end
  end

  // capture sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= BCTR_IDLE;
    else if (clr)
      state <= BCTR_IDLE;
    else
      case (state)
        BCTR_IDLE: if (ctrl[`BCTR_CTRL_EN]) state <= BCTR_RUN;
        BCTR_RUN: if (we_mark) state <= BCTR_DONE;
          else if (start_now && dly_len == 16'h0000) state <= BCTR_DONE;
          else if (start_now) state <= BCTR_DELAY;
        BCTR_DELAY: if (we_mark || dly_expire) state <= BCTR_DONE;
        default: state <= state;
      endcase
  end

  // delay start reference and delay counting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dly_seen <= 1'b0;
      ref_reg <= 8'h00;
      ref_insn_reg <= 16'h0000;
      dly_cnt <= 16'h0000;
    end
    else if (clr)
    begin
      dly_seen <= 1'b0;
      dly_cnt <= 16'h0000;
    end
    else if (start_now)
    begin
      dly_seen <= 1'b1; // R12
      ref_reg <= wptr; // R12
      ref_insn_reg <= insn_no;
      dly_cnt <= 16'h0001;
    end
    else if (we_cyc && state == BCTR_DELAY)
      dly_cnt <= dly_cnt + 16'h0001; // R13
  end

  // end-of-run marker request, held until a free cycle writes it or capture ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mark_pend <= 1'b0;
    else if (clr || we_mark || !capturing)
      mark_pend <= run_end & capturing & ~we_mark;
    else if (run_end)
      mark_pend <= 1'b1; // R18
  end

  // instruction numbering; the marker adds none
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      insn_no <= 16'h0000;
      last_insn <= 16'h0000;
    end
    else if (clr)
    begin
      insn_no <= 16'h0000;
      last_insn <= 16'h0000;
    end
    else if (we_cyc)
    begin
      insn_no <= insn_no + {14'h0000, tgt.insn_cnt}; // R15 R16
      last_insn <= insn_no;
    end
  end

  // cycles since last bus cycle end, stuck at the top value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_run <= 8'h00;
    else if (cyc_end)
      clk_run <= 8'h00;
    else if (clk_run != `BCTR_CLK_MAX)
      clk_run <= clk_run + 8'h01; // R9
  end

  // free-running time stamp
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tstamp <= 32'h00000000;
    else
      tstamp <= tstamp + 32'h00000001;
  end

  // software control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `BCTR_CTRL_RST; // R11 R16
      dly_len <= `BCTR_DLY_RST;
      sel <= `BCTR_SEL_RST;
    end
    else if (apb_wr)
      case (paddr)
        `BCTR_OFF_CTRL: ctrl <= pwdata[2:0]; // R11
        `BCTR_OFF_DLY: dly_len <= pwdata[15:0];
        `BCTR_OFF_SEL: sel <= pwdata[15:0];
        default: ctrl <= ctrl;
      endcase
  end

  // reference point: delay start entry, or else the latest entry
  assign ref_pos = dly_seen ? ref_reg : wptr - 8'h01; // R12 R14
  assign ref_insn = dly_seen ? ref_insn_reg : last_insn; // R14
  assign rd_rec = mem[ref_pos + sel[7:0]];
  assign idx_val = ctrl[`BCTR_CTRL_IDXBUS] ? sel : rd_rec.insn_no - ref_insn; // R16

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~reg_hit(paddr);
      prdata <= 32'h00000000;
      if (apb_acc && !pwrite)
        case (paddr)
          `BCTR_OFF_CTRL: prdata <= {29'h00000000, ctrl};
          `BCTR_OFF_DLY: prdata <= {16'h0000, dly_len};
          `BCTR_OFF_STAT: prdata <= {wrapped, dly_seen, mark_pend, 6'h00, state, 1'b0, dly_cnt[11:0], wptr};
          `BCTR_OFF_SEL: prdata <= {16'h0000, sel};
          `BCTR_OFF_EADDR: prdata <= rd_rec.addr;
          `BCTR_OFF_EDATA: prdata <= rd_rec.data;
          `BCTR_OFF_EINFO: prdata <= rd_rec.info;
          `BCTR_OFF_ETIME: prdata <= rd_rec.time_val;
          `BCTR_OFF_EIDX: prdata <= {{16{idx_val[15]}}, idx_val};
          default: prdata <= 32'h00000000;
        endcase
    end
  end

  // busy flag for the target side
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trace_busy <= 1'b0;
    else
      trace_busy <= capturing;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_acc_start;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_apb_answer;
    s_acc_start |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer not in one cycle");

  property p_capture;
    we_cyc && !clr |=> wptr == $past(wptr) + 8'h01;
  endproperty
  a_capture: assert property (p_capture) else $error("bus cycle not stored"); // R1

  property p_lanes;
    we_cyc && tgt.size == BCTR_SZ_BYTE |-> $countones(next_rec.info.lanes) == 1 && next_rec.info.marker == 1'b0;
  endproperty
  a_lanes: assert property (p_lanes) else $error("byte access lane mask wrong"); // R8

  property p_sat;
    clk_run == `BCTR_CLK_MAX && !cyc_end |=> clk_run == `BCTR_CLK_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("clock count not saturated"); // R9

  property p_one_field;
    we_cyc && !ctrl[`BCTR_CTRL_TS] |-> next_rec.time_val[31:8] == 24'h000000 && next_rec.time_val[7:0] != 8'h00;
  endproperty
  a_one_field: assert property (p_one_field) else $error("clock count field malformed"); // R10

  property p_ts_off;
    !ctrl[`BCTR_CTRL_TS] && !(apb_wr && paddr == `BCTR_OFF_CTRL) |=> !ctrl[`BCTR_CTRL_TS];
  endproperty
  a_ts_off: assert property (p_ts_off) else $error("time stamp turned on without a write"); // R11

  property p_ref;
    start_now && !clr |=> dly_seen && ref_pos == $past(wptr);
  endproperty
  a_ref: assert property (p_ref) else $error("delay reference not at start entry"); // R12 R13

  property p_latest;
    !dly_seen |-> ref_pos == wptr - 8'h01;
  endproperty
  a_latest: assert property (p_latest) else $error("reference not latest entry"); // R14

  sequence s_marker_write;
    we_mark && !clr;
  endsequence
  property p_marker;
    s_marker_write |=> state == BCTR_DONE && insn_no == $past(insn_no) && wptr == $past(wptr) + 8'h01;
  endproperty
  a_marker: assert property (p_marker) else $error("marker entry mishandled"); // R18

  property p_insn;
    we_cyc && !clr |=> insn_no == $past(insn_no) + {14'h0000, $past(tgt.insn_cnt)};
  endproperty
  a_insn: assert property (p_insn) else $error("instruction count not advanced"); // R15
endmodule // bctr_top

// file: sim/bctr_target_model.sv
// target bus model: one sample per bus cycle, idle clocks between cycles
module bctr_target_model
(
  // clock
  input wire logic pclk,
  // bus towards the recorder
  output bctr_pkg::bctr_bus_t tgt,
  output logic cyc_end
);
  timeunit 1ns / 1ps;
  import bctr_pkg::*;
  initial
  begin
    tgt = '0;
    cyc_end = 1'b0;
  end
  // idle clock: bus released, so the last sample must not linger
  task automatic idle();
    cyc_end <= 1'b0;
    tgt <= ~tgt;
    @(posedge pclk);
  endtask
  // g idle clocks, then the end strobe with its sample for one clock
  task automatic cycle(input bctr_bus_t b, input int g);
    repeat (g) idle();
    tgt <= b;
    cyc_end <= 1'b1;
    @(posedge pclk);
  endtask
endmodule // bctr_target_model

// file: sim/bctr_top_test.sv
// self-checking bench of the bus-cycle trace recorder
`include "bctr_params.svh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module bctr_top_test;
  timeunit 1ns / 1ps;
  import bctr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic cyc_end, delay_start, run_end, trace_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, t1;
  bctr_bus_t tgt, b;
  bctr_bus_t h[$];
  int gp[$];
  int err_total, cmp_count, g;

  bctr_target_model u_tgt (.pclk(pclk), .tgt(tgt), .cyc_end(cyc_end));
  bctr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tgt(tgt),
    .cyc_end(cyc_end), .delay_start(delay_start), .run_end(run_end), .trace_busy(trace_busy));

  // bench clock, 10 ns period
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one apb transfer; the wait for pready has no bound of its own
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] lmask(input logic [3:0] l);
    for (int i = 0; i < 4; i++)
      lmask[8*i +: 8] = {8{l[i]}};
  endfunction

  // expected lanes, big-endian: lane 3 carries byte offset 0
  function automatic logic [3:0] elane(input bctr_bus_t x);
    if (x.size == BCTR_SZ_LONG)
      return 4'hF;
    if (x.size == BCTR_SZ_WORD)
      return x.addr[1] ? 4'h3 : 4'hC;
    return 4'h8 >> x.addr[1:0];
  endfunction

  function automatic int nl(input bctr_bus_t x);
    return x.size == BCTR_SZ_BYTE ? 1 : (x.size == BCTR_SZ_WORD ? 2 : 4);
  endfunction

  function automatic bctr_info_t einfo(input bctr_bus_t x, input logic [3:0] l, input logic ovf);
    bctr_area_t ar;
    ar = x.io_hit ? BCTR_AREA_IO : (x.int_hit ? BCTR_AREA_INT : BCTR_AREA_EXT);
    return '{6'h00, x.insn_cnt, ovf, 1'b0, x.probe, x.vcc_ok, x.bus_request_level, x.res, x.nmi, x.interrupt_request_level, x.sts, x.rw, ar, l};
  endfunction

  // random sample; area hits are exclusive, enums kept legal
  function automatic bctr_bus_t rbus();
    bctr_bus_t x;
    int k;
    x = $bits(x)'({$urandom, $urandom, $urandom});
    k = $urandom_range(2);
    x.size = bctr_size_t'($urandom_range(2));
    x.sts = bctr_sts_t'($urandom_range(4));
    x.io_hit = (k == 0);
    x.int_hit = (k == 1);
    x.insn_cnt = 2'($urandom_range(2));
    return x;
  endfunction

  // read back the entry at relative index k; c is the clock count, 0 skips it
  task automatic ent(input int k, input bctr_bus_t x, input int c);
    logic [3:0] l;
    apb(1'b1, `BCTR_OFF_SEL, 32'(k));
    apb(1'b0, `BCTR_OFF_EINFO, '0);
    l = rd[3:0];
    `CHK("lanes", nl(x), $countones(l))
    `CHK("info", 32'(einfo(x, elane(x), c > 255)), rd)
    apb(1'b0, `BCTR_OFF_EADDR, '0);
    `CHK("addr", x.addr, rd)
    apb(1'b0, `BCTR_OFF_EDATA, '0);
    `CHK("data", x.data & lmask(elane(x)), rd)
    apb(1'b0, `BCTR_OFF_EIDX, '0);
    `CHK("index", 32'(k), rd)
    if (c > 0)
    begin
      apb(1'b0, `BCTR_OFF_ETIME, '0);
      `CHK("clocks", 32'(c > 255 ? 255 : c), rd)
    end
  endtask

  // n cycles with gap gg (negative: random 0..3), logged for checking
  task automatic run(input int n, input int gg);
    for (int i = 0; i < n; i++)
    begin
      b = rbus();
      g = gg < 0 ? $urandom_range(3) : gg;
      u_tgt.cycle(b, g);
      h.push_back(b);
      gp.push_back(g + 1);
    end
    u_tgt.idle();
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {delay_start, run_end, presetn} = '0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `BCTR_OFF_CTRL, '0);
    `CHK("ctrl", 32'h00000000, rd)
    apb(1'b0, 8'h24, '0);
    `CHK("unmapped", 1'b1, er)
    // random capture, bus index then instruction index, reference is the latest entry
    apb(1'b1, `BCTR_OFF_CTRL, 32'h5);
    run(8, -1);
    for (int k = 0; k < 8; k++)
      ent(-k, h[7-k], k == 7 ? 0 : gp[7-k]);
    apb(1'b1, `BCTR_OFF_CTRL, 32'h1);
    apb(1'b1, `BCTR_OFF_SEL, -32'sd3);
    apb(1'b0, `BCTR_OFF_EIDX, '0);
    `CHK("insn", -32'(h[4].insn_cnt + h[5].insn_cnt + h[6].insn_cnt), rd)
    // saturating count, then time stamps replace it
    apb(1'b1, `BCTR_OFF_CTRL, 32'h5);
    run(1, 300);
    ent(0, h[8], 301);
    apb(1'b1, `BCTR_OFF_CTRL, 32'h7);
    run(2, 5);
    apb(1'b0, `BCTR_OFF_ETIME, '0);
    t1 = rd;
    apb(1'b1, `BCTR_OFF_SEL, -32'sd1);
    apb(1'b0, `BCTR_OFF_ETIME, '0);
    `CHK("stamp", 32'd6, t1 - rd)
    // delay start: three before, two after, later cycles refused
    apb(1'b1, `BCTR_OFF_DLY, 32'h2);
    apb(1'b1, `BCTR_OFF_CTRL, 32'hD);
    h.delete();
    run(3, 1);
    delay_start <= 1'b1;
    run(1, 0);
    delay_start <= 1'b0;
    run(4, 1);
    apb(1'b0, `BCTR_OFF_STAT, '0);
    `CHK("state", 10'h306, {rd[22:21], rd[7:0]})
    `CHK("busy", 1'b0, trace_busy)
    ent(0, h[3], 2);
    ent(2, h[5], 2);
    ent(-1, h[2], 2);
    // marker entry after the last user cycle
    apb(1'b1, `BCTR_OFF_CTRL, 32'hD);
    h.delete();
    run(2, 1);
    run_end <= 1'b1;
    u_tgt.idle();
    run_end <= 1'b0;
    u_tgt.idle();
    apb(1'b0, `BCTR_OFF_STAT, '0);
    `CHK("mstat", 10'h303, {rd[22:21], rd[7:0]})
    apb(1'b1, `BCTR_OFF_SEL, 32'h0);
    apb(1'b0, `BCTR_OFF_EINFO, '0);
    `CHK("marker", 1'b1, rd[22])
    ent(-1, h[1], 2);
    // wrap of the circular store
    apb(1'b1, `BCTR_OFF_CTRL, 32'hD);
    h.delete();
    run(260, 0);
    apb(1'b0, `BCTR_OFF_STAT, '0);
    `CHK("wrap", 9'h104, {rd[31], rd[7:0]})
    ent(-255, h[4], 1);
    stop_test();
  end

  // watchdog well beyond the expected run time
  initial
  begin
    #200us;
    err_total++;
    stop_test();
  end
endmodule // bctr_top_test
